// [ucf_uart_flags.sv]
// serial port control, flag and interrupt identification logic with its two data FIFOs
`timescale 1ns/1ps
`include "ucf_cfg.svh"

module ucf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys, // port clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic [CW-1:0] capLimit, // words that may be held at most
  input wire logic inValid, // write side offers a word
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word written
  output logic outValid, // a word is held
  input wire logic outReady, // read side takes the word
  output logic [WIDTH-1:0] outData, // oldest word
  output logic [CW-1:0] count // words held
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q < capLimit) && (count_q < CW'(DEPTH));
  assign outValid = count_q != '0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_q];
  assign count = count_q;

  function automatic logic [AW-1:0] ptrNext(input logic [AW-1:0] p);
    ptrNext = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= ptrNext(wrPtr_q);
      end
      if (pop) begin
        rdPtr_q <= ptrNext(rdPtr_q);
      end
      if (push && !pop) begin
        count_q <= CW'(count_q + 1'b1);
      end else if (pop && !push) begin
        count_q <= CW'(count_q - 1'b1);
      end
    end
  end
endmodule

module ucf_uart_flags #(
  parameter int DEPTH = `UCF_FIFO_DEPTH,
  parameter int IDLE_BITS = `UCF_IDLE_BITS
) (
  input wire logic clk_sys, // port clock, 20 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic [`UCF_ADDR_W-1:0] regAddr, // register byte address
  input wire logic [`UCF_DATA_W-1:0] regWrData, // write data
  input wire logic regWrStb, // one-cycle write strobe
  input wire logic regRdStb, // one-cycle read strobe
  output logic [`UCF_DATA_W-1:0] regRdData, // read data, valid the cycle after the strobe
  input wire logic fifo_on, // FIFO mode from the line control high byte
  input wire logic bitTick, // one pulse per serial bit period
  input wire logic rxValid, // receiver offers a character
  input wire logic [7:0] rxData, // received character
  output logic rxReady, // receive buffer takes the character
  output logic txValid, // transmit character waiting for the shifter
  output logic [7:0] txData, // transmit character
  input wire logic txReady, // shifter takes the character
  input wire logic txShiftBusy, // shifter still sending a frame
  input wire logic clear_to_send_n, // modem clear to send, active low
  input wire logic set_ready_n, // modem data set ready, active low
  input wire logic carrier_detect_n, // modem carrier detect, active low
  output logic combined_irq_line // combined interrupt, active high
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam int IW = $clog2(IDLE_BITS + 1);

  logic [7:0] ctrl_q;
  logic [2:0] modemS1_q;
  logic [2:0] modemS2_q;
  logic [2:0] modemS3_q;
  logic modemRaw_q;
  logic idleRaw_q;
  logic [IW-1:0] idleCnt_q;
  logic [`UCF_DATA_W-1:0] regRdData_q;
  logic portOn;
  logic modemChange;
  logic [CW-1:0] capLimit;
  logic [CW-1:0] rxCount;
  logic [CW-1:0] txCount;
  logic rxOutValid;
  logic [7:0] rxOutData;
  logic rxPop;
  logic txInReady;
  logic txPush;
  logic rxFifoReady;
  logic txFifoValid;
  logic rxIrq;
  logic txIrq;
  logic [3:0] ident;
  logic [7:0] flags;
  ucf_pkg::ucf_reg_type wrSel;
  ucf_pkg::ucf_reg_type rdSel;

  function automatic ucf_pkg::ucf_reg_type decode(input logic [`UCF_ADDR_W-1:0] a);
    unique case (a)
      `UCF_OFF_DATA: decode = ucf_pkg::UCF_REG_DATA;
      `UCF_OFF_CTRL: decode = ucf_pkg::UCF_REG_CTRL;
      `UCF_OFF_FLAGS: decode = ucf_pkg::UCF_REG_FLAGS;
      `UCF_OFF_IDENT: decode = ucf_pkg::UCF_REG_IDENT;
      default: decode = ucf_pkg::UCF_REG_NONE;
    endcase
  endfunction

  assign wrSel = decode(regAddr);
  assign rdSel = decode(regAddr);
  assign portOn = ctrl_q[`UCF_BIT_PORT_ON];

  assign capLimit = fifo_on ? FULL : CW'(1);

  assign rxReady = portOn && rxFifoReady;
  assign txValid = portOn && txFifoValid;
  assign rxPop = regRdStb && (rdSel == ucf_pkg::UCF_REG_DATA) && portOn;
  assign txPush = regWrStb && (wrSel == ucf_pkg::UCF_REG_DATA) && portOn;

  ucf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .capLimit(capLimit),
    .inValid(rxValid && portOn),
    .inReady(rxFifoReady),
    .inData(rxData),
    .outValid(rxOutValid),
    .outReady(rxPop),
    .outData(rxOutData),
    .count(rxCount)
  );

  ucf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .capLimit(capLimit),
    .inValid(txPush),
    .inReady(txInReady),
    .inData(regWrData),
    .outValid(txFifoValid),
    .outReady(txReady && portOn),
    .outData(txData),
    .count(txCount)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `UCF_CTRL_RESET;
    end else if (regWrStb && wrSel == ucf_pkg::UCF_REG_CTRL) begin
      ctrl_q <= regWrData & `UCF_CTRL_MASK;
    end
  end

  // two-stage synchroniser, third stage for edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      modemS1_q <= `UCF_SYNC_RESET;
      modemS2_q <= `UCF_SYNC_RESET;
      modemS3_q <= `UCF_SYNC_RESET;
    end else begin
      modemS1_q <= {carrier_detect_n, set_ready_n, clear_to_send_n};
      modemS2_q <= modemS1_q;
      modemS3_q <= modemS2_q;
    end
  end

  assign modemChange = modemS2_q != modemS3_q;

  // sticky modem change, set wins over clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      modemRaw_q <= 1'b0;
    end else if (modemChange) begin
      modemRaw_q <= 1'b1;
    end else if (regWrStb && wrSel == ucf_pkg::UCF_REG_IDENT) begin
      modemRaw_q <= 1'b0;
    end
  end

  // idle bit count while data waits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idleCnt_q <= '0;
      idleRaw_q <= 1'b0;
    end else begin
      if (rxCount == '0 || (rxValid && rxReady)) begin
        idleCnt_q <= '0;
      end else if (bitTick && idleCnt_q < IW'(IDLE_BITS)) begin
        idleCnt_q <= IW'(idleCnt_q + 1'b1);
      end
      if (rxCount == '0) begin
        idleRaw_q <= 1'b0;
      end else if (bitTick && idleCnt_q == IW'(IDLE_BITS - 1)) begin
        idleRaw_q <= 1'b1;
      end
    end
  end

  assign rxIrq = fifo_on ? (rxCount >= HALF) : (rxCount != '0);
  assign txIrq = fifo_on ? (txCount <= HALF) : (txCount == '0);

  assign ident[`UCF_IDENT_MODEM] = modemRaw_q && ctrl_q[`UCF_BIT_MODEM_EN];
  assign ident[`UCF_IDENT_RX] = rxIrq && ctrl_q[`UCF_BIT_RX_EN];
  assign ident[`UCF_IDENT_TX] = txIrq && ctrl_q[`UCF_BIT_TX_EN];
  assign ident[`UCF_IDENT_IDLE] = idleRaw_q && ctrl_q[`UCF_BIT_IDLE_EN];

  assign combined_irq_line = |ident;

  always_comb begin
    flags = '0;
    flags[`UCF_FLAG_CTS] = !modemS2_q[0];
    flags[`UCF_FLAG_DSR] = !modemS2_q[1];
    flags[`UCF_FLAG_DCD] = !modemS2_q[2];
    flags[`UCF_FLAG_BUSY] = (txCount != '0) || txShiftBusy;
    flags[`UCF_FLAG_RX_EMPTY_FLAG] = rxCount == '0;
    flags[`UCF_FLAG_RX_FULL_FLAG] = rxCount >= capLimit;
    flags[`UCF_FLAG_TX_FULL_FLAG] = txCount >= capLimit;
    flags[`UCF_FLAG_TX_EMPTY_FLAG] = txCount == '0;
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdData_q <= '0;
    end else if (regRdStb) begin
      unique case (rdSel)
        ucf_pkg::UCF_REG_DATA: regRdData_q <= (rxOutValid && portOn) ? rxOutData : '0;
        ucf_pkg::UCF_REG_CTRL: regRdData_q <= ctrl_q;
        ucf_pkg::UCF_REG_FLAGS: regRdData_q <= flags;
        ucf_pkg::UCF_REG_IDENT: regRdData_q <= {4'h0, ident};
        ucf_pkg::UCF_REG_NONE: regRdData_q <= '0;
      endcase
    end else begin
      regRdData_q <= '0;
    end
  end

  assign regRdData = regRdData_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence identWrite;
    regWrStb && regAddr == `UCF_OFF_IDENT && !modemChange;
  endsequence

  sequence modemEdgeEnabled;
    modemChange && ctrl_q[`UCF_BIT_MODEM_EN];
  endsequence

  a_port_off_quiet: assert property (!portOn |-> !rxReady && !txValid)
    else $error("port moves data while disabled");
  a_modem_edge_irq: assert property (modemEdgeEnabled ##1 ctrl_q[`UCF_BIT_MODEM_EN] |-> combined_irq_line)
    else $error("modem change did not raise interrupt");
  a_rx_half_irq: assert property (fifo_on && ctrl_q[`UCF_BIT_RX_EN] |-> ident[1] == (rxCount >= CW'(DEPTH / 2)))
    else $error("receive level interrupt wrong");
  a_rx_char_read: assert property (!fifo_on && rxCount == CW'(1) && rxPop ##1 !fifo_on |-> !rxIrq)
    else $error("one read did not clear receive interrupt");
  a_tx_half_irq: assert property (fifo_on && ctrl_q[`UCF_BIT_TX_EN] && txCount > CW'(DEPTH / 2) |-> !ident[2])
    else $error("transmit interrupt above half");
  a_tx_char_write: assert property (!fifo_on && txCount == '0 && txPush && !txReady ##1 !fifo_on |-> !txIrq)
    else $error("one write did not clear transmit interrupt");
  a_idle_clear: assert property (rxCount == '0 |=> !idleRaw_q)
    else $error("timeout held with receive buffer empty");
  a_busy_flag: assert property (txPush |=> flags[`UCF_FLAG_BUSY])
    else $error("busy flag not set by a transmit write");
  a_modem_clear: assert property (identWrite |=> !modemRaw_q ##1 1'b1)
    else $error("ident write did not clear modem interrupt");
  a_char_depth: assert property (!fifo_on && $stable(fifo_on) |-> rxCount <= CW'(1) || $past(fifo_on))
    else $error("character mode holds more than one byte");
  a_irq_line_or: assert property (combined_irq_line == (ident != 4'h0))
    else $error("combined line does not match sources");
  a_read_timing: assert property (regRdStb && regAddr == `UCF_OFF_CTRL |=> regRdData == $past(ctrl_q))
    else $error("read data not presented the next cycle");
  a_rx_empty_flag: assert property (rxValid && rxReady |=> !flags[`UCF_FLAG_RX_EMPTY_FLAG])
    else $error("receive empty flag set after a character arrived");
  a_tx_full_flag: assert property (!fifo_on && txPush ##1 !fifo_on |-> flags[`UCF_FLAG_TX_FULL_FLAG])
    else $error("transmit full flag clear with holding byte written");
  a_rx_full_flag: assert property (!fifo_on && rxValid && rxReady ##1 !fifo_on |-> flags[`UCF_FLAG_RX_FULL_FLAG])
    else $error("receive full flag clear with holding byte filled");
  a_tx_empty_flag: assert property (txValid && txReady && txCount == CW'(1) && !txPush
    |=> flags[`UCF_FLAG_TX_EMPTY_FLAG])
    else $error("transmit empty flag clear after last byte left");
  a_modem_sync: assert property ($changed({carrier_detect_n, set_ready_n, clear_to_send_n})
    |-> ##2 modemChange)
    else $error("modem input change not seen after two stages");
endmodule

// [ucf_cfg.svh]
// register offsets, field positions, reset values and counts of the serial port control block
`ifndef UCF_CFG_SVH
`define UCF_CFG_SVH

`define UCF_ADDR_W 8
`define UCF_DATA_W 8
`define UCF_OFF_DATA 8'h00
`define UCF_OFF_CTRL 8'h14
`define UCF_OFF_FLAGS 8'h18
`define UCF_OFF_IDENT 8'h1c

`define UCF_CTRL_RESET 8'h00
`define UCF_CTRL_MASK 8'h79
`define UCF_BIT_PORT_ON 0
`define UCF_BIT_MODEM_EN 3
`define UCF_BIT_RX_EN 4
`define UCF_BIT_TX_EN 5
`define UCF_BIT_IDLE_EN 6

`define UCF_FLAG_CTS 0
`define UCF_FLAG_DSR 1
`define UCF_FLAG_DCD 2
`define UCF_FLAG_BUSY 3
`define UCF_FLAG_RX_EMPTY_FLAG 4
`define UCF_FLAG_TX_FULL_FLAG 5
`define UCF_FLAG_RX_FULL_FLAG 6
`define UCF_FLAG_TX_EMPTY_FLAG 7

`define UCF_IDENT_MODEM 0
`define UCF_IDENT_RX 1
`define UCF_IDENT_TX 2
`define UCF_IDENT_IDLE 3

`define UCF_FIFO_DEPTH 32
`define UCF_IDLE_BITS 32
`define UCF_SYNC_RESET 3'h7

`endif

// [ucf_pkg.sv]
// types shared by the serial port control block
package ucf_pkg;

  typedef enum logic [2:0] {
    UCF_REG_DATA,
    UCF_REG_CTRL,
    UCF_REG_FLAGS,
    UCF_REG_IDENT,
    UCF_REG_NONE
  } ucf_reg_type;

endpackage

// [ucf_far_model.sv]
// far-side model: receiver and transmitter front end with the modem status lines
`timescale 1ns/1ps
module ucf_far_model #(
  parameter int TICK_DIV = 4,
  parameter int FRAME = 12
) (
  input wire logic clk_sys, // port clock
  input wire logic nrst, // reset, active low
  input wire logic txStall, // holds the shifter off
  output logic bitTick, // bit period pulse
  output logic rxValid, // received character offered
  output logic [7:0] rxData, // received character
  input wire logic rxReady, // device takes the character
  input wire logic txValid, // device offers a character
  input wire logic [7:0] txData, // character to send
  output logic txReady, // shifter takes the character
  output logic txShiftBusy, // frame still on the line
  output logic clear_to_send_n, // modem clear to send
  output logic set_ready_n, // modem data set ready
  output logic carrier_detect_n // modem carrier detect
);
  logic [7:0] gotQ[$];
  logic [2:0] modemN = 3'h7;
  int tickCnt;
  int busyCnt;
  assign {carrier_detect_n, set_ready_n, clear_to_send_n} = modemN;
  assign txShiftBusy = busyCnt != 0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tickCnt <= 0;
      bitTick <= 1'b0;
    end else begin
      tickCnt <= (tickCnt == TICK_DIV - 1) ? 0 : tickCnt + 1;
      bitTick <= tickCnt == TICK_DIV - 1;
    end
  end
  // shifter accepts one character per frame unless stalled
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busyCnt <= 0;
      txReady <= 1'b0;
    end else if (txValid && txReady) begin
      gotQ.push_back(txData);
      busyCnt <= FRAME;
      txReady <= 1'b0;
    end else begin
      if (busyCnt != 0)
        busyCnt <= busyCnt - 1;
      txReady <= !txStall && busyCnt <= 1;
    end
  end
  // character held until taken, then the data line no longer shows it
  task automatic sendChar(input logic [7:0] c);
    @(posedge clk_sys);
    rxValid <= 1'b1;
    rxData <= c;
    @(posedge clk_sys);
    while (rxReady !== 1'b1)
      @(posedge clk_sys);
    rxValid <= 1'b0;
    rxData <= ~c;
  endtask
  task automatic setLine(input int i, input logic v);
    @(posedge clk_sys);
    modemN[i] <= v;
  endtask
endmodule

// [ucf_uart_flags_tb.sv]
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`include "ucf_cfg.svh"
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin numErrors++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module ucf_uart_flags_tb;
  localparam int DEPTH = 32;
  localparam int IDLE = 4;
  localparam int FRAME = 12;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic fifo_on = 1'b0;
  logic txStall = 1'b1;
  logic [7:0] regRdData, rxData, txData;
  logic bitTick, rxValid, rxReady, txValid, txReady, txShiftBusy, irq;
  logic clear_to_send_n, set_ready_n, carrier_detect_n;
  int numErrors = 0;
  int numChecks = 0;
  always #25 clk_sys = ~clk_sys;
  ucf_uart_flags #(.DEPTH(DEPTH), .IDLE_BITS(IDLE)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .fifo_on(fifo_on), .bitTick(bitTick), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
    .txShiftBusy(txShiftBusy), .clear_to_send_n(clear_to_send_n), .set_ready_n(set_ready_n),
    .carrier_detect_n(carrier_detect_n), .combined_irq_line(irq));
  ucf_far_model #(.TICK_DIV(4), .FRAME(FRAME)) far_u (
    .clk_sys(clk_sys), .nrst(nrst), .txStall(txStall), .bitTick(bitTick), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady), .txShiftBusy(txShiftBusy),
    .clear_to_send_n(clear_to_send_n), .set_ready_n(set_ready_n), .carrier_detect_n(carrier_detect_n));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask
  task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1;
    `CHK(n, e, regRdData)
  endtask
  task automatic waitTx(input int n);
    for (int i = 0; i < 3000 && far_u.gotQ.size() < n; i++)
      @(posedge clk_sys);
    repeat (FRAME + 2) @(posedge clk_sys);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    numErrors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rdChk("flags", `UCF_OFF_FLAGS, 8'h90);
    rdChk("ident", `UCF_OFF_IDENT, 8'h00);
    rdChk("ctrl", `UCF_OFF_CTRL, 8'h00);
    rdChk("unmapped", 8'h20, 8'h00);
    `CHK("rxReady", 1'b0, rxReady)
    wr(`UCF_OFF_DATA, 8'h11);
    rdChk("flags", `UCF_OFF_FLAGS, 8'h90);
    wr(`UCF_OFF_CTRL, 8'hff);
    rdChk("ctrl", `UCF_OFF_CTRL, 8'h79);
    wr(`UCF_OFF_CTRL, 8'h31);
    rdChk("ident", `UCF_OFF_IDENT, 8'h04);
    `CHK("irq", 1'b1, irq)
    wr(`UCF_OFF_DATA, 8'ha5);
    wr(`UCF_OFF_DATA, 8'h5a);
    rdChk("flags", `UCF_OFF_FLAGS, 8'h38);
    rdChk("ident", `UCF_OFF_IDENT, 8'h00);
    `CHK("irq", 1'b0, irq)
    @(posedge clk_sys);
    txStall <= 1'b0;
    for (int i = 0; i < 3000 && far_u.gotQ.size() < 1; i++)
      @(posedge clk_sys);
    rdChk("flags", `UCF_OFF_FLAGS, 8'h98);
    waitTx(1);
    rdChk("flags", `UCF_OFF_FLAGS, 8'h90);
    `CHK("txQ", 8'ha5, far_u.gotQ[0])
    `CHK("txQ size", 1, far_u.gotQ.size())
    far_u.sendChar(8'h3c);
    rdChk("flags", `UCF_OFF_FLAGS, 8'hc0);
    rdChk("ident", `UCF_OFF_IDENT, 8'h06);
    `CHK("rxReady", 1'b0, rxReady)
    rdChk("data", `UCF_OFF_DATA, 8'h3c);
    rdChk("ident", `UCF_OFF_IDENT, 8'h04);
    @(posedge clk_sys);
    fifo_on <= 1'b1;
    txStall <= 1'b1;
    for (int i = 0; i < DEPTH / 2; i++)
      wr(`UCF_OFF_DATA, 8'(i));
    rdChk("ident", `UCF_OFF_IDENT, 8'h04);
    wr(`UCF_OFF_DATA, 8'(DEPTH / 2));
    rdChk("ident", `UCF_OFF_IDENT, 8'h00);
    for (int i = DEPTH / 2 + 1; i < DEPTH; i++)
      wr(`UCF_OFF_DATA, 8'(i));
    wr(`UCF_OFF_DATA, 8'hee);
    rdChk("flags", `UCF_OFF_FLAGS, 8'h38);
    @(posedge clk_sys);
    txStall <= 1'b0;
    waitTx(1 + DEPTH);
    for (int i = 0; i < DEPTH; i++)
      `CHK("txQ", 8'(i), far_u.gotQ[1 + i])
    `CHK("txQ size", 1 + DEPTH, far_u.gotQ.size())
    rdChk("flags", `UCF_OFF_FLAGS, 8'h90);
    for (int i = 0; i < DEPTH / 2 - 1; i++)
      far_u.sendChar(8'(i + 64));
    rdChk("ident", `UCF_OFF_IDENT, 8'h04);
    far_u.sendChar(8'(DEPTH / 2 - 1 + 64));
    rdChk("ident", `UCF_OFF_IDENT, 8'h06);
    rdChk("data", `UCF_OFF_DATA, 8'h40);
    rdChk("ident", `UCF_OFF_IDENT, 8'h04);
    for (int i = DEPTH / 2; i <= DEPTH; i++)
      far_u.sendChar(8'(i + 64));
    rdChk("flags", `UCF_OFF_FLAGS, 8'hc0);
    `CHK("rxReady", 1'b0, rxReady)
    for (int i = 1; i <= DEPTH; i++)
      rdChk("data", `UCF_OFF_DATA, 8'(i + 64));
    rdChk("flags", `UCF_OFF_FLAGS, 8'h90);
    wr(`UCF_OFF_CTRL, 8'h41);
    far_u.sendChar(8'h77);
    rdChk("ident", `UCF_OFF_IDENT, 8'h00);
    repeat (IDLE * 4 * 2 + 8) @(posedge clk_sys);
    rdChk("ident", `UCF_OFF_IDENT, 8'h08);
    `CHK("irq", 1'b1, irq)
    rdChk("data", `UCF_OFF_DATA, 8'h77);
    rdChk("ident", `UCF_OFF_IDENT, 8'h00);
    wr(`UCF_OFF_CTRL, 8'h09);
    for (int k = 0; k < 3; k++) begin
      far_u.setLine(k, 1'b0);
      repeat (6) @(posedge clk_sys);
      rdChk("flags", `UCF_OFF_FLAGS, 8'h90 | (8'h01 << k));
      rdChk("ident", `UCF_OFF_IDENT, 8'h01);
      `CHK("irq", 1'b1, irq)
      wr(`UCF_OFF_IDENT, 8'(k * 85));
      rdChk("ident", `UCF_OFF_IDENT, 8'h00);
      far_u.setLine(k, 1'b1);
      repeat (6) @(posedge clk_sys);
      rdChk("ident", `UCF_OFF_IDENT, 8'h01);
      wr(`UCF_OFF_IDENT, 8'hff);
    end
    rdChk("flags", `UCF_OFF_FLAGS, 8'h90);
    conclude();
  end
endmodule
